// File: design/mvi_interrupt_unit.sv
// Multi-level vectored interrupt unit: pending, priority, vector fetch
//
// Overview of operation
// - Eight request levels 0..7; every source maps to exactly one level.
// - Level order follows the programmed level priority, not the level number.
// - Up to 128 vectors per level; 22 used, in-level order fixed.
// - Twenty-two sources, each with its own vector address.
// - On grant a flag clears by hardware, or by software write.
// - Within a level the lower vector address is granted first.
// - On grant, disable interrupts and push PC and flags during the high vector byte fetch.
// - Routine address is vector byte then next byte, joined to 16 bits.
// - Each external pin triggers on its selected rising or falling edge.
// - Basic timer overflow causes a reset via vector 100h, hardware cleared.
// - Level 0: timer A match at CEh, timer A overflow next; both clear ways.
// - Level 1: timer B match at D2h, cleared by hardware only.
// - Level 2: timer C at D4h, pulse-width overflow at D6h; both clear ways.
// - Level 3: timer D0/D1 match and overflow at D8h..DEh; both clear ways.
// - Level 4: serial port E4h, watch timer E6h; software clears.
// - Level 5: serial channels E8h..ECh, priorities 0..2; software clears.
// - Level 6: port 1 pins 0..3 at F0h..F6h; software clears.
// - Level 7: port 4 pins 0..3 at F8h..FEh; software clears.
// - A per-level mask enables or disables each level.
// - Global enable and disable instructions set or clear system mode bit 0.
`timescale 1ns/1ps
module mvi_interrupt_unit import mvi_pkg::*; #(
	parameter int NSRC = NUM_SRC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Internal peripheral events, sources 0..13, one-cycle pulses
	input wire logic [EXT_FIRST_SRC-1:0] periphEvent,
	// External pins: port 1 bits 0..3 then port 4 bits 0..3
	input wire logic [EXT_PINS-1:0] extPin,
	input wire logic [EXT_PINS-1:0] extRiseSelect,
	// Per-source enables and software clear strobes
	input wire logic [NSRC-1:0] sourceEnable,
	input wire logic [NSRC-1:0] softClear,
	// Level mask and level priority rank (0 = served first)
	input wire logic [NUM_LEVELS-1:0] levelMaskWrite,
	input wire logic levelMaskWe,
	input wire logic [NUM_LEVELS*LVL_IDX_W-1:0] levelRank,
	// Global enable and disable instructions
	input wire logic globalEnableInstr,
	input wire logic globalDisableInstr,
	// Basic timer overflow
	input wire logic basicTimerOvf,
	// CPU handshake
	input wire logic cpuAck,
	input wire logic pushDone,
	input wire logic fetchValid,
	input wire logic [7:0] fetchData,
	// Outputs to CPU
	output logic cpuRequest,
	output logic pushRequest,
	output logic fetchRequest,
	output logic [15:0] fetchAddr,
	output logic serviceStart,
	output logic [15:0] serviceAddr,
	output logic resetRequest,
	// Status
	output logic [NSRC-1:0] pending,
	output logic [NUM_LEVELS-1:0] levelRequest,
	output logic [NUM_LEVELS-1:0] levelMask,
	output logic globalEnable
);
	logic [EXT_PINS-1:0] edgeEvent;
	logic [NSRC-1:0] setEvent;
	logic [NSRC-1:0] pending_q;
	logic [NSRC-1:0] pending_d;
	logic [NUM_LEVELS-1:0] levelMask_q;
	logic [NUM_LEVELS-1:0] levelMask_d;
	logic globalEnable_q;
	logic globalEnable_d;
	logic resetRequest_q;
	logic resetRequest_d;
	mvi_state_type state_q;
	mvi_state_type state_d;
	logic [SRC_IDX_W-1:0] grantSrc_q;
	logic [SRC_IDX_W-1:0] grantSrc_d;
	logic [15:0] fetchAddr_q;
	logic [15:0] fetchAddr_d;
	logic [7:0] hiByte_q;
	logic [7:0] hiByte_d;
	logic [15:0] serviceAddr_q;
	logic [15:0] serviceAddr_d;
	logic serviceStart_q;
	logic serviceStart_d;
	logic [NSRC-1:0] active;
	logic [NUM_LEVELS-1:0] lvlReq;
	logic [SRC_IDX_W-1:0] lvlWinner [NUM_LEVELS];
	logic [SRC_IDX_W-1:0] winSrc;
	logic winValid;
	logic [LVL_IDX_W-1:0] bestRank;
	logic [NSRC-1:0] hwClear;

	// External pin edges feed sources 14..21
	mvi_edge_detect #(
		.WIDTH(EXT_PINS)
	) uEdge (
		.clk(clk),
		.reset_n(reset_n),
		.pinLevel(extPin),
		.riseSelect(extRiseSelect),
		.edgeEvent(edgeEvent)
	);

	assign setEvent = {edgeEvent, periphEvent};

	// Active sources: pending, enabled, level unmasked, global on
	genvar s;
	for (s = 0; s < NSRC; s++) begin : gActive
		assign active[s] = pending_q[s] & sourceEnable[s] & globalEnable_q
			& levelMask_q[LVL_TABLE[s*LVL_IDX_W +: LVL_IDX_W]];
	end

	// Per-level winner: lowest index is lowest vector address
	always_comb begin
		for (int l = 0; l < NUM_LEVELS; l++) begin
			lvlReq[l] = 1'b0;
			lvlWinner[l] = '0;
			for (int k = NSRC - 1; k >= 0; k--) begin
				if (active[k] && LVL_TABLE[k*LVL_IDX_W +: LVL_IDX_W] == l[2:0]) begin
					lvlReq[l] = 1'b1;
					lvlWinner[l] = k[SRC_IDX_W-1:0];
				end
			end
		end
	end

	// Level arbitration by programmed rank; ties go to the lower level number
	always_comb begin
		winValid = 1'b0;
		winSrc = '0;
		bestRank = '1;
		for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
			if (lvlReq[l] && (!winValid
				|| levelRank[l*LVL_IDX_W +: LVL_IDX_W] <= bestRank)) begin
				winValid = 1'b1;
				bestRank = levelRank[l*LVL_IDX_W +: LVL_IDX_W];
				winSrc = lvlWinner[l];
			end
		end
	end

	// Grant sequence: push together with high byte fetch, fetch low byte, enter
	always_comb begin
		state_d = state_q;
		grantSrc_d = grantSrc_q;
		fetchAddr_d = fetchAddr_q;
		hiByte_d = hiByte_q;
		serviceAddr_d = serviceAddr_q;
		serviceStart_d = 1'b0;
		hwClear = '0;
		unique case (state_q)
			MVI_IDLE: begin
				if (winValid && cpuAck && !resetRequest_q) begin
					grantSrc_d = winSrc;
					fetchAddr_d = {7'h00, VEC_TABLE[winSrc*VEC_W +: VEC_W]};
					hwClear[winSrc] = HW_CLEAR_MASK[winSrc];
					state_d = MVI_FETCH_HI;
				end
			end
			MVI_FETCH_HI: begin
				if (pushDone && fetchValid) begin
					hiByte_d = fetchData;
					fetchAddr_d = fetchAddr_q + {8'h00, WORD_ADDR_OFS};
					state_d = MVI_FETCH_LO;
				end
			end
			MVI_FETCH_LO: begin
				if (fetchValid) begin
					serviceAddr_d = {hiByte_q, fetchData};
					state_d = MVI_ENTER;
				end
			end
			MVI_ENTER: begin
				serviceStart_d = 1'b1;
				state_d = MVI_IDLE;
			end
		endcase
	end

	// Pending flags: set wins over any clear in the same cycle
	always_comb begin
		pending_d = (pending_q & ~hwClear & ~(softClear & SW_CLEAR_MASK))
			| setEvent;
	end

	// Global enable, level mask, reset request
	always_comb begin
		globalEnable_d = globalEnable_q;
		if (globalDisableInstr
			|| (state_q == MVI_IDLE && winValid && cpuAck && !resetRequest_q)) begin
			globalEnable_d = 1'b0;
		end else if (globalEnableInstr) begin
			globalEnable_d = 1'b1;
		end
		levelMask_d = levelMaskWe ? levelMaskWrite : levelMask_q;
		resetRequest_d = basicTimerOvf;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pending_q <= '0;
			levelMask_q <= LEVEL_MASK_RESET;
			globalEnable_q <= SYM_GLOBAL_RESET;
			resetRequest_q <= 1'b0;
			state_q <= MVI_IDLE;
			grantSrc_q <= '0;
			fetchAddr_q <= '0;
			hiByte_q <= '0;
			serviceAddr_q <= '0;
			serviceStart_q <= 1'b0;
		end else begin
			pending_q <= pending_d;
			levelMask_q <= levelMask_d;
			globalEnable_q <= globalEnable_d;
			resetRequest_q <= resetRequest_d;
			state_q <= state_d;
			grantSrc_q <= grantSrc_d;
			fetchAddr_q <= fetchAddr_d;
			hiByte_q <= hiByte_d;
			serviceAddr_q <= serviceAddr_d;
			serviceStart_q <= serviceStart_d;
		end
	end

	// Outputs; reset request carries vector 100h to the CPU
	assign cpuRequest = winValid && state_q == MVI_IDLE && !resetRequest_q;
	assign pushRequest = state_q == MVI_FETCH_HI;
	assign fetchRequest = state_q == MVI_FETCH_HI || state_q == MVI_FETCH_LO;
	assign fetchAddr = resetRequest_q ? {7'h00, VEC_BT_RESET} : fetchAddr_q;
	assign serviceStart = serviceStart_q;
	assign serviceAddr = serviceAddr_q;
	assign resetRequest = resetRequest_q;
	assign pending = pending_q;
	assign levelRequest = lvlReq;
	assign levelMask = levelMask_q;
	assign globalEnable = globalEnable_q;

	// Checks
	sequence seqGrant;
		state_q == MVI_IDLE && winValid && cpuAck && !resetRequest_q;
	endsequence

	chk_grant_disables: assert property (@(posedge clk) disable iff (!reset_n)
		seqGrant |=> !globalEnable_q) else $error("grant left interrupts enabled");
	chk_request_gating: assert property (@(posedge clk) disable iff (!reset_n)
		cpuRequest |-> globalEnable_q && (|(pending_q & sourceEnable)))
		else $error("request without enable");
	chk_mask_blocks: assert property (@(posedge clk) disable iff (!reset_n)
		(levelMask_q == 8'h00) |-> !cpuRequest) else $error("masked level requested");
	chk_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
		setEvent[0] |=> pending_q[0]) else $error("set lost against clear");
	chk_hw_only_b: assert property (@(posedge clk) disable iff (!reset_n)
		pending_q[2] && softClear[2] && !hwClear[2] |=> pending_q[2])
		else $error("timer B cleared by software");
	chk_sw_only_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(seqGrant and (winSrc >= 5'h09)) |=> pending_q[grantSrc_q])
		else $error("software-cleared flag cleared by grant");
	chk_vector_pair: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == MVI_FETCH_LO && fetchValid |=> serviceAddr_q == {hiByte_q, $past(fetchData)})
		else $error("service address not joined");
	chk_enter_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == MVI_ENTER |=> serviceStart_q ##1 !serviceStart_q)
		else $error("service start not one pulse");
	chk_in_level_order: assert property (@(posedge clk) disable iff (!reset_n)
		(seqGrant and active[0]) |=> grantSrc_q == 5'h00)
		else $error("timer A match lost in-level order");
	chk_global_instr: assert property (@(posedge clk) disable iff (!reset_n)
		globalEnableInstr && !globalDisableInstr && !cpuAck |=> globalEnable_q)
		else $error("enable instruction ignored");
	chk_reset_vector: assert property (@(posedge clk) disable iff (!reset_n)
		basicTimerOvf |=> resetRequest && fetchAddr == 16'h0100)
		else $error("basic timer reset vector wrong");
endmodule

// File: design/mvi_pkg.sv
// Package of constants and types for the multi-level vectored interrupt unit
package mvi_pkg;
	localparam int NUM_LEVELS = 8;
	localparam int NUM_SRC = 22;
	localparam int VEC_W = 9;
	localparam int SRC_IDX_W = 5;
	localparam int LVL_IDX_W = 3;
	// Vector addresses per source, in source index order
	localparam logic [VEC_W-1:0] VEC_TA_MATCH = 9'h0ce;
	localparam logic [VEC_W-1:0] VEC_TA_OVF = 9'h0d0;
	localparam logic [VEC_W-1:0] VEC_TB_MATCH = 9'h0d2;
	localparam logic [VEC_W-1:0] VEC_TC_MATCH = 9'h0d4;
	localparam logic [VEC_W-1:0] VEC_PWM_OVF = 9'h0d6;
	localparam logic [VEC_W-1:0] VEC_TD0_MATCH = 9'h0d8;
	localparam logic [VEC_W-1:0] VEC_TD0_OVF = 9'h0da;
	localparam logic [VEC_W-1:0] VEC_TD1_MATCH = 9'h0dc;
	localparam logic [VEC_W-1:0] VEC_TD1_OVF = 9'h0de;
	localparam logic [VEC_W-1:0] VEC_SSP = 9'h0e4;
	localparam logic [VEC_W-1:0] VEC_WT_OVF = 9'h0e6;
	localparam logic [VEC_W-1:0] VEC_SER_BASE = 9'h0e8;
	localparam logic [VEC_W-1:0] VEC_P1_BASE = 9'h0f0;
	localparam logic [VEC_W-1:0] VEC_P4_BASE = 9'h0f8;
	localparam logic [VEC_W-1:0] VEC_BT_RESET = 9'h100;
	// Source index to vector table; lower index is lower address
	localparam logic [NUM_SRC*VEC_W-1:0] VEC_TABLE = {
		9'h0fe, 9'h0fc, 9'h0fa, 9'h0f8, 9'h0f6, 9'h0f4, 9'h0f2, 9'h0f0,
		9'h0ec, 9'h0ea, 9'h0e8, 9'h0e6, 9'h0e4,
		9'h0de, 9'h0dc, 9'h0da, 9'h0d8, 9'h0d6, 9'h0d4, 9'h0d2, 9'h0d0, 9'h0ce};
	// Source index to level table, 3 bits each
	localparam logic [NUM_SRC*LVL_IDX_W-1:0] LVL_TABLE = {
		3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h6, 3'h6, 3'h6,
		3'h5, 3'h5, 3'h5, 3'h4, 3'h4,
		3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0};
	// Sources whose flag hardware clears on grant (levels 0..3)
	localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 22'h0001ff;
	// Sources whose flag software may clear (all but timer B)
	localparam logic [NUM_SRC-1:0] SW_CLEAR_MASK = 22'h3ffffb;
	localparam int EXT_PINS = 8;
	localparam int EXT_FIRST_SRC = 14;
	localparam int SYM_GLOBAL_BIT = 0;
	localparam logic SYM_GLOBAL_RESET = 1'b0;
	localparam logic [7:0] LEVEL_MASK_RESET = 8'h00;
	localparam logic [7:0] WORD_ADDR_OFS = 8'h01;
	typedef enum logic [1:0] {
		MVI_IDLE = 2'b00,
		MVI_FETCH_HI = 2'b01,
		MVI_FETCH_LO = 2'b10,
		MVI_ENTER = 2'b11
	} mvi_state_type;
endpackage

// File: design/mvi_edge_detect.sv
// Per-pin edge detector for the external interrupt inputs
`timescale 1ns/1ps
module mvi_edge_detect import mvi_pkg::*; #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Pins and edge choice, 1 selects rising
	input wire logic [WIDTH-1:0] pinLevel,
	input wire logic [WIDTH-1:0] riseSelect,
	// One-cycle edge events
	output logic [WIDTH-1:0] edgeEvent
);
	logic [WIDTH-1:0] prevLevel_q;
	logic [WIDTH-1:0] prevLevel_d;

	// Previous level kept so each pin sees one event per transition
	always_comb begin
		prevLevel_d = pinLevel;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prevLevel_q <= '0;
		end else begin
			prevLevel_q <= prevLevel_d;
		end
	end

	// Edge choice per pin
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : gEdge
		assign edgeEvent[i] = riseSelect[i] ? (pinLevel[i] & ~prevLevel_q[i])
			: (~pinLevel[i] & prevLevel_q[i]);
	end
endmodule

// File: test/mvi_cpu_model.sv
// CPU side model: acknowledges requests, completes the push and the vector byte reads
`timescale 1ns/1ps
module mvi_cpu_model import mvi_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Requests from the unit
	input wire logic cpuRequest,
	input wire logic pushRequest,
	input wire logic fetchRequest,
	input wire logic [15:0] fetchAddr,
	// Bench controls
	input wire logic ackEnable,
	input wire logic slowMode,
	// Answers
	output logic cpuAck,
	output logic pushDone,
	output logic fetchValid,
	output logic [7:0] fetchData
);
	logic tick;
	logic go;
	// Slow mode answers only every other cycle
	assign go = ~slowMode | tick;
	// Answers move on the falling edge so they stand across the sampling edge
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick <= 1'b0;
			cpuAck <= 1'b0;
			pushDone <= 1'b0;
			fetchValid <= 1'b0;
			fetchData <= 8'h00;
		end else begin
			tick <= ~tick;
			cpuAck <= cpuRequest & ackEnable & go;
			pushDone <= pushRequest & go;
			fetchValid <= fetchRequest & go;
			// Idle data bus flips so a stale byte never looks valid
			fetchData <= (go & fetchRequest) ? (fetchAddr[7:0] ^ 8'h5a) : ~fetchData;
		end
	end
endmodule

// File: test/tb.sv
// Self-checking testbench of the multi-level vectored interrupt unit
`timescale 1ns/1ps
module tb import mvi_pkg::*; ;
	localparam logic [7:0] VEC [14] = '{8'hce, 8'hd0, 8'hd2, 8'hd4, 8'hd6, 8'hd8, 8'hda,
		8'hdc, 8'hde, 8'he4, 8'he6, 8'he8, 8'hea, 8'hec};
	logic clk, reset_n, levelMaskWe, globalEnableInstr, globalDisableInstr, basicTimerOvf;
	logic cpuAck, pushDone, fetchValid, cpuRequest, pushRequest, fetchRequest;
	logic serviceStart, resetRequest, globalEnable, ackEnable, slowMode;
	logic [13:0] periphEvent;
	logic [7:0] extPin, extRiseSelect, levelMaskWrite, fetchData, levelRequest, levelMask;
	logic [21:0] sourceEnable, softClear, pending;
	logic [23:0] levelRank;
	logic [15:0] fetchAddr, serviceAddr;
	int err_total = 0;
	int n_checks = 0;
	mvi_interrupt_unit u_mvi_interrupt_unit (.clk(clk), .reset_n(reset_n),
		.periphEvent(periphEvent), .extPin(extPin), .extRiseSelect(extRiseSelect),
		.sourceEnable(sourceEnable), .softClear(softClear), .levelMaskWrite(levelMaskWrite),
		.levelMaskWe(levelMaskWe), .levelRank(levelRank), .globalEnableInstr(globalEnableInstr),
		.globalDisableInstr(globalDisableInstr), .basicTimerOvf(basicTimerOvf), .cpuAck(cpuAck),
		.pushDone(pushDone), .fetchValid(fetchValid), .fetchData(fetchData),
		.cpuRequest(cpuRequest), .pushRequest(pushRequest), .fetchRequest(fetchRequest),
		.fetchAddr(fetchAddr), .serviceStart(serviceStart), .serviceAddr(serviceAddr),
		.resetRequest(resetRequest), .pending(pending), .levelRequest(levelRequest),
		.levelMask(levelMask), .globalEnable(globalEnable));
	mvi_cpu_model u_mvi_cpu_model (.clk(clk), .reset_n(reset_n), .cpuRequest(cpuRequest),
		.pushRequest(pushRequest), .fetchRequest(fetchRequest), .fetchAddr(fetchAddr),
		.ackEnable(ackEnable), .slowMode(slowMode), .cpuAck(cpuAck), .pushDone(pushDone),
		.fetchValid(fetchValid), .fetchData(fetchData));
	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chkAddr(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t address %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic chkFlag(input logic [21:0] got, input logic [21:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t flags %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ei;
		globalEnableInstr = 1'b1;
		cyc(1);
		globalEnableInstr = 1'b0;
	endtask
	task automatic clr(input logic [21:0] m);
		softClear = m;
		cyc(1);
		softClear = '0;
	endtask
	// Waits for the routine start and checks the joined address
	task automatic serve(input logic [7:0] v);
		int k;
		for (k = 0; k < 40 && serviceStart !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 40) begin
			$display("CHECK FAILED %0t no service start", $time);
			err_total++;
			conclude();
		end
		chkAddr(serviceAddr, {v ^ 8'h5a, (v + 8'h01) ^ 8'h5a});
		chkFlag(globalEnable, 22'h0);
		cyc(1);
	endtask
	// Every internal source alone gives its own vector
	task automatic scTable;
		for (int i = 0; i < 14; i++) begin
			periphEvent[i] = 1'b1;
			cyc(1);
			periphEvent = '0;
			ei();
			serve(VEC[i]);
			clr('1);
		end
	endtask
	// Two sources of one level at once, then hardware clear
	task automatic scOrder;
		periphEvent = 14'h0003;
		cyc(1);
		periphEvent = '0;
		ei();
		serve(8'hce);
		chkFlag(pending, 22'h000002);
		ei();
		serve(8'hd0);
		chkFlag(pending, 22'h0);
	endtask
	// Level rank beats level number; timer B ignores software clear
	task automatic scRank;
		levelRank = {8{3'h7}};
		levelRank[14:12] = 3'h0;
		levelRank[5:3] = 3'h5;
		periphEvent = 14'h0204;
		cyc(1);
		periphEvent = '0;
		ei();
		serve(8'he4);
		chkFlag(pending, 22'h000204);
		clr(22'h000204);
		chkFlag(pending, 22'h000004);
		ei();
		serve(8'hd2);
		chkFlag(pending, 22'h0);
		levelRank = '0;
	endtask
	// Level mask, global disable, source enable, then a slow partner
	task automatic scGate;
		ackEnable = 1'b0;
		levelMaskWrite = 8'hfe;
		levelMaskWe = 1'b1;
		cyc(1);
		levelMaskWe = 1'b0;
		periphEvent[0] = 1'b1;
		cyc(1);
		periphEvent = '0;
		ei();
		cyc(2);
		chkFlag(cpuRequest, 22'h0);
		chkFlag(levelRequest, 22'h0);
		levelMaskWrite = 8'hff;
		levelMaskWe = 1'b1;
		cyc(1);
		levelMaskWe = 1'b0;
		chkFlag(cpuRequest, 22'h1);
		chkFlag(levelRequest, 22'h1);
		globalDisableInstr = 1'b1;
		cyc(1);
		globalDisableInstr = 1'b0;
		chkFlag({globalEnable, cpuRequest}, 22'h0);
		ei();
		chkFlag(globalEnable, 22'h1);
		sourceEnable[0] = 1'b0;
		cyc(1);
		chkFlag(cpuRequest, 22'h0);
		sourceEnable = '1;
		slowMode = 1'b1;
		ackEnable = 1'b1;
		serve(8'hce);
		slowMode = 1'b0;
	endtask
	// Pin edges follow the edge choice
	task automatic scExt;
		extRiseSelect = 8'h01;
		extPin = 8'h10;
		cyc(3);
		chkFlag(pending, 22'h0);
		extPin = 8'h01;
		cyc(3);
		chkFlag(pending, 22'h044000);
		ei();
		serve(8'hf0);
		clr(22'h004000);
		ei();
		serve(8'hf8);
		clr('1);
	endtask
	// Basic timer overflow takes the reset path and blocks grants
	task automatic scBasic;
		basicTimerOvf = 1'b1;
		periphEvent[0] = 1'b1;
		cyc(1);
		periphEvent = '0;
		ei();
		cyc(2);
		chkFlag({resetRequest, cpuRequest}, 22'h2);
		chkAddr(fetchAddr, 16'h0100);
		basicTimerOvf = 1'b0;
		serve(8'hce);
	endtask
	// A stuck handshake cannot hang the run
	initial begin
		#1000000;
		$display("CHECK FAILED %0t run timeout", $time);
		err_total++;
		conclude();
	end
	// Main sequence
	initial begin
		{reset_n, levelMaskWe, globalEnableInstr, globalDisableInstr, basicTimerOvf} = '0;
		{periphEvent, extPin, extRiseSelect, levelMaskWrite, softClear, levelRank} = '0;
		{slowMode, sourceEnable, ackEnable} = '1;
		slowMode = 1'b0;
		cyc(20);
		reset_n = 1'b1;
		cyc(1);
		chkFlag(pending, 22'h0);
		chkFlag({levelMask, globalEnable, cpuRequest}, 22'h0);
		levelMaskWrite = 8'hff;
		levelMaskWe = 1'b1;
		cyc(1);
		levelMaskWe = 1'b0;
		scTable();
		scOrder();
		scRank();
		scGate();
		scExt();
		scBasic();
		conclude();
	end
endmodule
